// file: core/rui_pkg.sv
// Constants and types shared by the update and alarm interrupt block
package rui_pkg;
	// Register offsets
	localparam logic [7:0] ADR_SEC = 8'h01;
	localparam logic [7:0] ADR_MIN = 8'h02;
	localparam logic [7:0] ADR_HR = 8'h03;
	localparam logic [7:0] ADR_DATE = 8'h05;
	localparam logic [7:0] ADR_AMIN = 8'h08;
	localparam logic [7:0] ADR_AHR = 8'h09;
	localparam logic [7:0] ADR_ADATE = 8'h0A;
	localparam logic [7:0] ADR_STAT = 8'h0D;
	localparam logic [7:0] ADR_CTL1 = 8'h10;
	localparam logic [7:0] ADR_CTL2 = 8'h11;
	localparam logic [7:0] ADR_CKMSK = 8'h14;
	// Field positions
	localparam int UPD_SEL_BIT = 4;
	localparam int HALT_BIT = 5;
	localparam int UPD_EN_BIT = 5;
	localparam int ALM_EN_BIT = 3;
	localparam int UPD_FLAG_BIT = 5;
	localparam int ALM_FLAG_BIT = 3;
	localparam int INT_DLY_BIT = 7;
	localparam int CK_UPD_BIT = 2;
	localparam int CK_ALM_BIT = 3;
	localparam int AE_BIT = 7;
	// Values after reset and BCD limits
	localparam logic [7:0] TIME_RST = 8'h00;
	localparam logic [7:0] DATE_RST = 8'h01;
	localparam logic [7:0] ALARM_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] MIN_TOP = 8'h59;
	localparam logic [7:0] HR_TOP = 8'h23;
	localparam logic [7:0] DATE_TOP = 8'h31;
	// Timing
	localparam longint CLK_HZ = 100000000;
	localparam longint RTC_HZ = 6250000;
	localparam longint REL_SEC_MS = 500;
	localparam longint REL_MIN_US = 15600;
	localparam longint REL_SEC_CYC = (REL_SEC_MS * CLK_HZ) / 1000;
	localparam longint REL_MIN_CYC = (REL_MIN_US * CLK_HZ) / 1000000;
	localparam longint RTC_SEC_CYC = RTC_HZ;
	localparam int REL_W = 26;
	localparam int PRE_W = 23;
	localparam logic [4:0] INT_DLY_CYC = 5'h10;
	localparam logic [2:0] CLOCK_OUTPUT_PIN_HALF = 3'h4;
	// Serial bus slave address, value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEF = 7'h2C;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD} rui_bus_st_t;
endpackage

// file: core/rui_top.sv
// Update and alarm interrupt logic with serial register port and time base
`timescale 1ns/1ns
module rui_top
	import rui_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter longint SEC_CYC = RTC_SEC_CYC,
	parameter longint REL_SEC = REL_SEC_CYC,
	parameter longint REL_MIN = REL_MIN_CYC
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RTC_CLK,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	output logic INT_N_O,
	output logic INT_N_OE,
	output logic CLOCK_OUTPUT_PIN_PIN
);

	function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] lo);
		if (v == top) begin
			bcd_step = lo;
		end else if (v[3:0] == 4'h9) begin
			bcd_step = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_step = v + 8'h01;
		end
	endfunction

	// Registers
	logic [7:0] sec_r, min_r, hr_r, date_r;
	logic [7:0] amin_r, ahr_r, adate_r;
	logic [7:0] ctl1_r, ctl2_r, ckmsk_r;
	logic upd_flag_r, alm_flag_r;
	logic swr_tg_r;

	// Serial port state
	rui_bus_st_t st_r;
	logic [3:0] cnt_r;
	logic [7:0] sr_r, tx_r, ptr_r, wr_ptr_r, wr_dat_r;
	logic rw_r, nack_r, sda_oe_r, wr_stb_r;
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;

	// Time base domain
	logic [1:0] rs_r;
	logic halt_s1_r, halt_s2_r;
	logic swr_s1_r, swr_s2_r, swr_s3_r;
	logic [PRE_W-1:0] pre_r;
	logic tick_tg_r;
	logic tk_s1_r, tk_s2_r, tk_s3_r;

	// Interrupt and clock output state
	logic min_tick_r;
	logic [REL_W-1:0] rel_r;
	logic [4:0] dly_r;
	logic [2:0] div_r;
	logic ck_r, int_oe_r;

	wire halt = ctl1_r[HALT_BIT];
	wire upd_sel = ctl1_r[UPD_SEL_BIT];
	wire upd_en = ctl2_r[UPD_EN_BIT];
	wire alm_en = ctl2_r[ALM_EN_BIT];

	// The seconds counter of the time base lives on the oscillator clock
	always_ff @(posedge RTC_CLK) begin
		rs_r <= {rs_r[0], SYS_RST};
		halt_s1_r <= halt;
		halt_s2_r <= halt_s1_r;
		swr_s1_r <= swr_tg_r;
		swr_s2_r <= swr_s1_r;
		swr_s3_r <= swr_s2_r;
	end

	wire rtc_rst = rs_r[1];
	wire swr_evt = swr_s2_r ^ swr_s3_r;
	wire pre_end = pre_r == PRE_W'(SEC_CYC - 1);

	always_ff @(posedge RTC_CLK) begin
		if (rtc_rst) begin
			pre_r <= '0;
			tick_tg_r <= 1'b0;
		end else if (halt_s2_r || swr_evt) begin
			pre_r <= '0;
		end else if (pre_end) begin
			pre_r <= '0;
			tick_tg_r <= ~tick_tg_r;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// Second tick crosses as a toggle
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			tk_s1_r <= 1'b0;
			tk_s2_r <= 1'b0;
			tk_s3_r <= 1'b0;
		end else begin
			tk_s1_r <= tick_tg_r;
			tk_s2_r <= tk_s1_r;
			tk_s3_r <= tk_s2_r;
		end
	end

	wire sec_tick = (tk_s2_r ^ tk_s3_r) && !halt;
	wire sec_wrap = sec_tick && sec_r == MIN_TOP;
	wire min_wrap = sec_wrap && min_r == MIN_TOP;
	wire hr_wrap = min_wrap && hr_r == HR_TOP;

	// Register write decode
	wire w_sec = wr_stb_r && wr_ptr_r == ADR_SEC;
	wire w_min = wr_stb_r && wr_ptr_r == ADR_MIN;
	wire w_hr = wr_stb_r && wr_ptr_r == ADR_HR;
	wire w_date = wr_stb_r && wr_ptr_r == ADR_DATE;
	wire w_amin = wr_stb_r && wr_ptr_r == ADR_AMIN;
	wire w_ahr = wr_stb_r && wr_ptr_r == ADR_AHR;
	wire w_adate = wr_stb_r && wr_ptr_r == ADR_ADATE;
	wire w_stat = wr_stb_r && wr_ptr_r == ADR_STAT;
	wire w_ctl1 = wr_stb_r && wr_ptr_r == ADR_CTL1;
	wire w_ctl2 = wr_stb_r && wr_ptr_r == ADR_CTL2;
	wire w_ckmsk = wr_stb_r && wr_ptr_r == ADR_CKMSK;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sec_r <= TIME_RST;
			min_r <= TIME_RST;
			hr_r <= TIME_RST;
			date_r <= DATE_RST;
			swr_tg_r <= 1'b0;
		end else begin
			if (w_sec) begin
				sec_r <= wr_dat_r & 8'h7F;
				swr_tg_r <= ~swr_tg_r;
			end else if (sec_tick) begin
				sec_r <= bcd_step(sec_r, MIN_TOP, TIME_RST);
			end
			if (w_min) begin
				min_r <= wr_dat_r & 8'h7F;
			end else if (sec_wrap) begin
				min_r <= bcd_step(min_r, MIN_TOP, TIME_RST);
			end
			if (w_hr) begin
				hr_r <= wr_dat_r & 8'h3F;
			end else if (min_wrap) begin
				hr_r <= bcd_step(hr_r, HR_TOP, TIME_RST);
			end
			if (w_date) begin
				date_r <= wr_dat_r & 8'h3F;
			end else if (hr_wrap) begin
				date_r <= bcd_step(date_r, DATE_TOP, DATE_RST);
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			amin_r <= ALARM_RST;
			ahr_r <= ALARM_RST;
			adate_r <= ALARM_RST;
			ctl1_r <= CTL_RST;
			ctl2_r <= CTL_RST;
			ckmsk_r <= CTL_RST;
		end else begin
			if (w_amin) begin
				amin_r <= wr_dat_r;
			end
			if (w_ahr) begin
				ahr_r <= wr_dat_r;
			end
			if (w_adate) begin
				adate_r <= wr_dat_r;
			end
			if (w_ctl1) begin
				ctl1_r <= wr_dat_r;
			end
			if (w_ctl2) begin
				ctl2_r <= wr_dat_r;
			end
			if (w_ckmsk) begin
				ckmsk_r <= wr_dat_r;
			end
		end
	end

	// Alarm compares the fresh minute, one cycle after the rollover
	wire am_m = amin_r[AE_BIT] || amin_r[6:0] == min_r[6:0];
	wire am_h = ahr_r[AE_BIT] || ahr_r[5:0] == hr_r[5:0];
	wire am_d = adate_r[AE_BIT] || adate_r[5:0] == date_r[5:0];
	wire alm_dead = !adate_r[AE_BIT] && adate_r[5:0] == 6'h00;
	wire alm_evt = min_tick_r && am_m && am_h && am_d && !alm_dead && !halt;

	wire upd_evt = upd_sel ? sec_wrap : sec_tick;
	wire upd_take = upd_evt && upd_en;
	wire upd_flag_clr = w_stat && !wr_dat_r[UPD_FLAG_BIT];
	wire alm_flag_clr = w_stat && !wr_dat_r[ALM_FLAG_BIT];

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			min_tick_r <= 1'b0;
			upd_flag_r <= 1'b0;
			alm_flag_r <= 1'b0;
		end else begin
			min_tick_r <= sec_wrap;
			upd_flag_r <= upd_take || (upd_flag_r && !upd_flag_clr);
			alm_flag_r <= alm_evt || (alm_flag_r && !alm_flag_clr);
		end
	end

	wire [REL_W-1:0] rel_load = upd_sel ? REL_W'(REL_MIN) : REL_W'(REL_SEC);

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rel_r <= '0;
		end else if (upd_take) begin
			rel_r <= rel_load;
		end else if (!upd_flag_r || !upd_en) begin
			rel_r <= '0;
		end else if (rel_r != '0) begin
			rel_r <= rel_r - 1'b1;
		end
	end

	wire upd_req = rel_r != '0 && upd_flag_r && upd_en;
	wire alm_req = alm_flag_r && alm_en;
	wire ck_upd = upd_flag_r && upd_en && ckmsk_r[CK_UPD_BIT];
	wire ck_alm = alm_flag_r && alm_en && ckmsk_r[CK_ALM_BIT];
	wire ck_on = ck_upd || ck_alm;
	// Delay only matters while the clock output is on, whichever source turns it on
	wire dly_ok = !ckmsk_r[INT_DLY_BIT] || !ck_on || dly_r == INT_DLY_CYC;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			dly_r <= 5'h00;
		end else if (!ck_on) begin
			dly_r <= 5'h00;
		end else if (dly_r != INT_DLY_CYC) begin
			dly_r <= dly_r + 5'h01;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			div_r <= 3'h0;
			ck_r <= 1'b0;
			int_oe_r <= 1'b0;
		end else begin
			int_oe_r <= (upd_req || alm_req) && dly_ok;
			if (!ck_on) begin
				div_r <= 3'h0;
				ck_r <= 1'b0;
			end else if (div_r == CLOCK_OUTPUT_PIN_HALF - 3'h1) begin
				div_r <= 3'h0;
				ck_r <= ~ck_r;
			end else begin
				div_r <= div_r + 3'h1;
			end
		end
	end

	// Serial register port, pins sampled on the system clock
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_s3_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_s3_r <= 1'b1;
		end else begin
			scl_s1_r <= SCL_I;
			scl_s2_r <= scl_s1_r;
			scl_s3_r <= scl_s2_r;
			sda_s1_r <= SDA_I;
			sda_s2_r <= sda_s1_r;
			sda_s3_r <= sda_s2_r;
		end
	end

	wire scl_rise = scl_s2_r && !scl_s3_r;
	wire scl_fall = !scl_s2_r && scl_s3_r;
	wire scl_high = scl_s2_r && scl_s3_r;
	wire bus_start = scl_high && sda_s3_r && !sda_s2_r;
	wire bus_stop = scl_high && !sda_s3_r && sda_s2_r;
	wire [7:0] stat_rd = 8'(upd_flag_r) << UPD_FLAG_BIT | 8'(alm_flag_r) << ALM_FLAG_BIT;
	// Unmapped offsets read as zero
	wire [7:0] rd_mux =
		ptr_r == ADR_SEC ? sec_r :
		ptr_r == ADR_MIN ? min_r :
		ptr_r == ADR_HR ? hr_r :
		ptr_r == ADR_DATE ? date_r :
		ptr_r == ADR_AMIN ? amin_r :
		ptr_r == ADR_AHR ? ahr_r :
		ptr_r == ADR_ADATE ? adate_r :
		ptr_r == ADR_STAT ? stat_rd :
		ptr_r == ADR_CTL1 ? ctl1_r :
		ptr_r == ADR_CTL2 ? ctl2_r :
		ptr_r == ADR_CKMSK ? ckmsk_r : 8'h00;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			st_r <= ST_IDLE;
			cnt_r <= 4'h0;
			sr_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_ptr_r <= 8'h00;
			wr_dat_r <= 8'h00;
		end else begin
			wr_stb_r <= 1'b0;
			if (bus_start) begin
				st_r <= ST_ADDR;
				cnt_r <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (bus_stop) begin
				st_r <= ST_IDLE;
				sda_oe_r <= 1'b0;
			end else if (st_r != ST_IDLE && scl_rise) begin
				if (cnt_r < 4'h8) begin
					sr_r <= {sr_r[6:0], sda_s2_r};
					cnt_r <= cnt_r + 4'h1;
				end else begin
					nack_r <= sda_s2_r;
				end
			end else if (st_r != ST_IDLE && scl_fall) begin
				if (cnt_r == 4'h8) begin
					cnt_r <= 4'h9;
					case (st_r)
						ST_ADDR: begin
							if (sr_r[7:1] == DEV_ADDR) begin
								sda_oe_r <= 1'b1;
								rw_r <= sr_r[0];
							end else begin
								st_r <= ST_IDLE;
							end
						end
						ST_PTR: begin
							ptr_r <= sr_r;
							sda_oe_r <= 1'b1;
						end
						ST_WR: begin
							wr_stb_r <= 1'b1;
							wr_ptr_r <= ptr_r;
							wr_dat_r <= sr_r;
							ptr_r <= ptr_r + 8'h01;
							sda_oe_r <= 1'b1;
						end
						default: begin
							sda_oe_r <= 1'b0;
						end
					endcase
				end else if (cnt_r == 4'h9) begin
					cnt_r <= 4'h0;
					sda_oe_r <= 1'b0;
					if ((st_r == ST_ADDR && rw_r) || (st_r == ST_RD && !nack_r)) begin
						st_r <= ST_RD;
						tx_r <= rd_mux;
						sda_oe_r <= ~rd_mux[7];
						ptr_r <= ptr_r + 8'h01;
					end else if (st_r == ST_RD) begin
						st_r <= ST_IDLE;
					end else if (st_r == ST_ADDR) begin
						st_r <= ST_PTR;
					end else begin
						st_r <= ST_WR;
					end
				end else if (st_r == ST_RD) begin
					tx_r <= {tx_r[6:0], 1'b0};
					sda_oe_r <= ~tx_r[6];
				end
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			SDA_O <= 1'b0;
			SDA_OE <= 1'b0;
			INT_N_O <= 1'b0;
			INT_N_OE <= 1'b0;
			CLOCK_OUTPUT_PIN_PIN <= 1'b0;
		end else begin
			SDA_O <= 1'b0;
			SDA_OE <= sda_oe_r;
			INT_N_O <= 1'b0;
			INT_N_OE <= int_oe_r;
			CLOCK_OUTPUT_PIN_PIN <= ck_r;
		end
	end

endmodule

// file: tb/rui_chk.sv
// Checker for the interrupt, clock output and serial pins
`timescale 1ns/1ns
module rui_chk #(
	parameter longint REL_SEC = 1500
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic RTC_CLK,
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire logic INT_N_O,
	input wire logic INT_N_OE,
	input wire logic CLOCK_OUTPUT_PIN_PIN
);
	int hi_n;
	// Length of the current low stretch on the interrupt line
	always_ff @(posedge CLOCK) begin
		if (SYS_RST || !INT_N_OE) begin
			hi_n <= 0;
		end else begin
			hi_n <= hi_n + 1;
		end
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	chk_int_width_cap: assert property (hi_n <= REL_SEC + 4)
		else $error("interrupt held too long");
	chk_int_min_width: assert property ($rose(INT_N_OE) |-> INT_N_OE [*8])
		else $error("interrupt pulse too short");
	chk_quiet_after_reset: assert property ($fell(SYS_RST) |->
		(!INT_N_OE && !CLOCK_OUTPUT_PIN_PIN) [*8])
		else $error("output active right after reset");
	chk_reset_outputs: assert property (disable iff (1'b0)
		SYS_RST [*2] |-> !INT_N_OE && !CLOCK_OUTPUT_PIN_PIN && !SDA_OE)
		else $error("output active in reset");
	chk_clock_output_pin_high: assert property ($rose(CLOCK_OUTPUT_PIN_PIN) |-> ##4 !CLOCK_OUTPUT_PIN_PIN)
		else $error("clock output high phase wrong");
	chk_clock_output_pin_low: assert property ($fell(CLOCK_OUTPUT_PIN_PIN) |-> !CLOCK_OUTPUT_PIN_PIN [*4])
		else $error("clock output low phase short");
	chk_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
		else $error("data changed with bus clock high");
	chk_int_drive_zero: assert property (INT_N_O == 1'b0)
		else $error("interrupt pin drives high");
	chk_sda_drive_zero: assert property (SDA_O == 1'b0)
		else $error("data pin drives high");
	cover property ($rose(INT_N_OE));
	cover property ($rose(CLOCK_OUTPUT_PIN_PIN));
	cover property ($rose(SDA_OE));
endmodule
bind rui_top rui_chk #(.REL_SEC(REL_SEC)) u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.RTC_CLK(RTC_CLK), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
	.INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE), .CLOCK_OUTPUT_PIN_PIN(CLOCK_OUTPUT_PIN_PIN));

// file: tb/rui_host.sv
// Host model: serial bus master for register frames
`timescale 1ns/1ns
module rui_host
	import rui_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic hc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Data moves mid low phase, clear of both clock edges
	task automatic bt(input logic b, output logic r);
		sda_oe = !b;
		hc(5);
		scl = 1'b1;
		hc(10);
		r = sda;
		scl = 1'b0;
		hc(5);
	endtask
	task automatic st();
		sda_oe = 1'b0;
		hc(5);
		scl = 1'b1;
		hc(10);
		sda_oe = 1'b1;
		hc(10);
		scl = 1'b0;
		hc(5);
	endtask
	task automatic by(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], r);
			q[i] = r;
		end
		bt(1'b1, r);
		ack = !r;
	endtask
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		logic k1;
		logic k2;
		logic k3;
		logic k4;
		st();
		by({DEV_ADDR, 1'b0}, q, k1);
		by(a, q, k2);
		if (rd) begin
			st();
			by({DEV_ADDR, 1'b1}, q, k3);
			by(8'hFF, q, k4);
		end else begin
			by(d, q, k3);
		end
		sda_oe = 1'b1;
		hc(5);
		scl = 1'b1;
		hc(10);
		sda_oe = 1'b0;
		hc(10);
		ok = k1 && k2 && k3;
	endtask
endmodule

// file: tb/test_rui_top.sv
// Testbench: registers, update, alarm and clock output scenarios
`timescale 1ns/1ns
module test_rui_top
	import rui_pkg::*;
;
	localparam int SECN = 3200;
	localparam int RS = 1500;
	localparam int RM = 40;
	logic CLOCK = 1'b0;
	logic SYS_RST = 1'b1;
	logic RTC_CLK = 1'b0;
	logic SCL_I, SDA_I, SDA_O, SDA_OE, INT_N_O, INT_N_OE, CLOCK_OUTPUT_PIN_PIN, host_oe;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	assign SDA_I = !(host_oe || SDA_OE === 1'b1);
	always #5 CLOCK = ~CLOCK;
	initial begin
		#33;
		forever #80 RTC_CLK = ~RTC_CLK;
	end
	rui_top #(.SEC_CYC(200), .REL_SEC(RS), .REL_MIN(RM)) dut (.CLOCK(CLOCK),
		.SYS_RST(SYS_RST), .RTC_CLK(RTC_CLK), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
		.SDA_OE(SDA_OE), .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE), .CLOCK_OUTPUT_PIN_PIN(CLOCK_OUTPUT_PIN_PIN));
	rui_host host (.clk(CLOCK), .sda(SDA_I), .scl(SCL_I), .sda_oe(host_oe));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(negedge CLOCK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic ok;
		host.xfer(1'b0, a, d, q, ok);
		cmp("ack", 32'h1, ok);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic ok;
		host.xfer(1'b1, a, 8'h00, q, ok);
		cmp($sformatf("reg %h", a), e, q);
	endtask
	task automatic quiet(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin
			tk(1);
			hit = hit | (INT_N_OE !== 1'b0);
		end
		cmp("int idle", 32'h0, hit);
	endtask
	task automatic rise(output int n);
		n = 0;
		while (INT_N_OE !== 1'b1 && n < 4000) begin
			tk(1);
			n++;
		end
		cmp("int raised", 32'h1, n < 4000);
	endtask
	task automatic width(output int w);
		w = 0;
		while (INT_N_OE === 1'b1 && w < 5000) begin
			tk(1);
			w++;
		end
	endtask
	task automatic t_regs();
		rc(ADR_CTL2, CTL_RST);
		rc(ADR_ADATE, ALARM_RST);
		rc(8'h04, 8'h00);
		wr(ADR_AMIN, 8'hA5);
		rc(ADR_AMIN, 8'hA5);
	endtask
	task automatic t_upd();
		int n;
		int w;
		wr(ADR_CTL1, 8'h20);
		wr(ADR_CTL2, 8'h20);
		quiet(SECN + 800);
		wr(ADR_CTL1, 8'h00);
		rise(n);
		cmp("first update", 32'h1, n > SECN - 400);
		width(w);
		cmp("sec release", 32'h1, w >= RS - 3 && w <= RS + 3);
		rc(ADR_STAT, 8'h20);
		rise(n);
		wr(ADR_STAT, 8'h00);
		tk(5);
		cmp("flag clear", 32'h0, INT_N_OE);
		rise(n);
		wr(ADR_CTL2, 8'h00);
		tk(5);
		cmp("enable clear", 32'h0, INT_N_OE);
		wr(ADR_STAT, 8'h00);
		quiet(SECN + 400);
		rc(ADR_STAT, 8'h00);
	endtask
	task automatic t_min();
		int n;
		int w;
		wr(ADR_CTL1, 8'h10);
		wr(ADR_CTL2, 8'h20);
		wr(ADR_SEC, 8'h59);
		rise(n);
		cmp("sec write", 32'h1, n > SECN - 400);
		width(w);
		cmp("min release", 32'h1, w >= RM - 3 && w <= RM + 3);
		rc(ADR_STAT, 8'h20);
		rc(ADR_MIN, 8'h01);
	endtask
	task automatic t_alm();
		int n;
		wr(ADR_CTL2, 8'h00);
		wr(ADR_STAT, 8'h00);
		wr(ADR_CTL1, 8'h00);
		wr(ADR_AMIN, 8'h80);
		wr(ADR_AHR, 8'h80);
		wr(ADR_ADATE, 8'h80);
		wr(ADR_SEC, 8'h59);
		quiet(SECN + 400);
		rc(ADR_STAT, 8'h08);
		wr(ADR_CTL2, 8'h08);
		cmp("alarm int", 32'h1, INT_N_OE);
		wr(ADR_STAT, 8'h00);
		wr(ADR_AMIN, 8'h03);
		wr(ADR_AHR, 8'h00);
		wr(ADR_CKMSK, 8'h08);
		wr(ADR_SEC, 8'h59);
		rise(n);
		cmp("alarm period", 32'h1, n > SECN - 400);
		n = 0;
		while (CLOCK_OUTPUT_PIN_PIN !== 1'b1 && n < 20) begin
			tk(1);
			n++;
		end
		cmp("alarm clock_output_pin", 32'h1, n < 20);
		wr(ADR_CTL2, 8'h00);
		wr(ADR_STAT, 8'h00);
		wr(ADR_AMIN, 8'h04);
		wr(ADR_AHR, 8'h01);
		wr(ADR_CTL2, 8'h08);
		wr(ADR_SEC, 8'h59);
		quiet(SECN + 400);
		wr(ADR_CTL2, 8'h00);
		wr(ADR_DATE, 8'h00);
		wr(ADR_AMIN, 8'h80);
		wr(ADR_AHR, 8'h80);
		wr(ADR_ADATE, 8'h00);
		wr(ADR_CTL2, 8'h08);
		wr(ADR_SEC, 8'h59);
		quiet(SECN + 400);
		rc(ADR_STAT, 8'h00);
	endtask
	task automatic t_clk();
		int n;
		wr(ADR_CTL2, 8'h00);
		wr(ADR_CKMSK, 8'h84);
		wr(ADR_CTL2, 8'h20);
		n = 0;
		while (CLOCK_OUTPUT_PIN_PIN !== 1'b1 && n < 4000) begin
			tk(1);
			n++;
		end
		cmp("clock_output_pin on", 32'h1, n < 4000);
		rise(n);
		cmp("int delay", 32'h1, n >= 11 && n <= 15);
		wr(ADR_STAT, 8'h00);
		tk(10);
		cmp("clock_output_pin off", 32'h0, CLOCK_OUTPUT_PIN_PIN);
		tk(4);
		cmp("clock_output_pin off", 32'h0, CLOCK_OUTPUT_PIN_PIN);
	endtask
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		// Longer than 16 cycles so the time-base domain also sees three edges
		tk(48);
		SYS_RST = 1'b0;
		tk(8);
		t_regs();
		t_upd();
		t_min();
		t_alm();
		t_clk();
		results();
	end
endmodule
